/* design/ipa_top.sv */
// Page-selective-within-domain invalidation unit with a small translation cache.
//
// Function
// - Address register takes writes; reads return nothing useful.
// - Register offset quadword aligned, advertised in capability.
// - Address bits above guest width are ignored.
// - Hint zero flushes leaf and non-leaf matches.
// - Hint one keeps non-leaf entries, flushes leaf.
// - Mask n ignores address bits 12 to 11+n.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "ipa_cfg.svh"
module ipa_top
   import ipa_pkg::*;
#(
   parameter int ENTRIES  = 8,   // Cached translation entries.
   parameter int MAX_GUEST_ADDR_WIDTH     = 48,  // Supported guest address width.
   parameter int DIDW     = 16,  // Domain identifier width.
   parameter int MAX_MASK = 9,   // Largest mask order accepted.
   parameter int IDXW     = $clog2(ENTRIES)
)
(
   input  wire logic               clk,          // System clock, 100 MHz.
   input  wire logic               sys_rst,      // Synchronous reset, active high.
   input  wire logic [7:0]         reg_addr,     // Register byte address.
   input  wire logic [31:0]        reg_wdata,    // Register write data.
   input  wire logic               reg_wr,       // Write strobe.
   input  wire logic               reg_rd,       // Read strobe.
   output logic      [31:0]        reg_rdata,    // Read data, cycle after the strobe.
   input  wire logic               fill_en,      // Load one cache entry.
   input  wire logic [IDXW-1:0]    fill_idx,     // Entry slot to load.
   input  wire logic               fill_leaf,    // Entry is a leaf translation.
   input  wire logic [DIDW-1:0]    fill_did,     // Entry domain.
   input  wire ipa_page_type       fill_page,    // Entry page number.
   input  wire logic               lk_en,        // Lookup request.
   input  wire logic [DIDW-1:0]    lk_did,       // Lookup domain.
   input  wire ipa_page_type       lk_page,      // Lookup page number.
   output logic                    lk_hit,       // Lookup found a valid entry.
   output logic                    lk_leaf,      // Found entry is a leaf.
   output logic                    inv_busy,     // Invalidation being applied.
   output logic      [ENTRIES-1:0] entry_valid   // Valid bit of every entry.
);
   // Elaboration check on parameters the logic cannot serve.
   if (ENTRIES < 2 || ENTRIES > 255 || MAX_GUEST_ADDR_WIDTH < 13 || MAX_GUEST_ADDR_WIDTH > 64 ||
       DIDW < 1 || DIDW > 16 || MAX_MASK < 0 || MAX_MASK > 52)
   begin : g_bad_param
      $error("ipa_top: unsupported parameter values");
   end

   // Keep mask of page bits below the guest width, and limits at register widths.
   localparam ipa_page_type MAX_GUEST_ADDR_WIDTH_KEEP = ipa_page_type'((53'h1 << (MAX_GUEST_ADDR_WIDTH - 12)) - 53'h1);
   localparam logic [5:0]   MAX_MASK_V = 6'(MAX_MASK);
   localparam logic [7:0]   MAX_GUEST_ADDR_WIDTH_V     = 8'(MAX_GUEST_ADDR_WIDTH);

   ipa_req_if #(.DIDW(DIDW)) req ();

   ipa_state_type     state_q;
   logic [DIDW-1:0]   did_q;
   logic              err_q;
   logic [31:0]       done_q;
   logic [31:0]       rdata_q;
   logic              lk_hit_q;
   logic              lk_leaf_q;
   logic [ENTRIES-1:0] valid_q;
   logic [ENTRIES-1:0] leaf_q;
   logic [DIDW-1:0]   did_mem  [ENTRIES];
   ipa_page_type      page_mem [ENTRIES];
   logic [ENTRIES-1:0] hit;
   logic              wr_lo;
   logic              wr_hi;
   logic              wr_cmd;
   logic              wr_stat;
   logic              go_req;
   logic              go_ok;
   logic              go_bad;
   logic [7:0]        valid_cnt;
   logic              lk_any;
   logic              lk_any_leaf;

   // Register write decode; the address words sit at a quadword-aligned offset.
   assign wr_lo   = reg_wr && (reg_addr == `IPA_IVA_LO_OFF);
   assign wr_hi   = reg_wr && (reg_addr == `IPA_IVA_HI_OFF);
   assign wr_cmd  = reg_wr && (reg_addr == `IPA_CMD_OFF);
   assign wr_stat = reg_wr && (reg_addr == `IPA_STAT_OFF);

   // The address register itself, a write-only store of page, hint and mask.
   ipa_addr_reg u_addr
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_lo   (wr_lo),
      .wr_hi   (wr_hi),
      .wdata   (reg_wdata),
      .req     (req.src)
   );

   // A command is refused while busy; an oversize mask is refused and flagged,
   // since a group larger than the reported maximum cannot be served exactly.
   assign go_req = wr_cmd && reg_wdata[`IPA_CMD_GO_BIT] && (state_q == IPA_IDLE);
   assign go_ok  = go_req && (req.mask <= MAX_MASK_V);
   assign go_bad = go_req && (req.mask > MAX_MASK_V);

   // Domain identifier of the command; upper bits beyond DIDW are not kept.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         did_q <= '0;
      else if (go_req)
         did_q <= reg_wdata[`IPA_CMD_DID_LSB +: DIDW];
   end

   // The latched domain completes the request seen by every comparator.
   assign req.domain_identifier = did_q;

   // One comparator per cache entry, all evaluated in the same cycle.
   for (genvar i = 0; i < ENTRIES; i++)
   begin : g_match
      ipa_match #(.MAX_GUEST_ADDR_WIDTH(MAX_GUEST_ADDR_WIDTH), .DIDW(DIDW)) u_match
      (
         .req       (req.dst),
         .ent_valid (valid_q[i]),
         .ent_did   (did_mem[i]),
         .ent_page  (page_mem[i]),
         .hit       (hit[i])
      );
   end

   // Sequencer: the request is taken in one cycle and applied in the next.
   // A single apply cycle suffices because all comparators work in parallel.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_q <= IPA_IDLE;
      else
      begin
         case (state_q)
            IPA_IDLE:
               if (go_ok)
                  state_q <= IPA_APPLY;
            IPA_APPLY:
               state_q <= IPA_IDLE;
            default:
               state_q <= IPA_IDLE;
         endcase
      end
   end

   // Busy marks the one cycle in which valid bits are cleared.
   assign inv_busy = (state_q == IPA_APPLY);

   // Valid bits: matching leaf entries always go; non-leaf entries go only when
   // the hint is clear. A fill landing in the apply cycle wins over the clear,
   // so a translation loaded after the command is never lost.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         valid_q <= '0;
      else
      begin
         for (int i = 0; i < ENTRIES; i++)
         begin
            if (fill_en && (fill_idx == IDXW'(i)))
               valid_q[i] <= 1'b1;
            else if (inv_busy && hit[i] && (leaf_q[i] || !req.hint))
               valid_q[i] <= 1'b0;
         end
      end
   end

   // Leaf flag of each slot; reset clears it along with the valid bit.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         leaf_q <= '0;
      else if (fill_en)
         leaf_q[fill_idx] <= fill_leaf;
   end

   // Domain and page of each slot; no reset is needed because the valid bit
   // gates every use, and leaving it out keeps the array a plain memory.
   always_ff @(posedge clk)
   begin
      if (fill_en)
      begin
         did_mem[fill_idx]  <= fill_did;
         page_mem[fill_idx] <= fill_page;
      end
   end

   // Valid bits are shown as they are stored.
   assign entry_valid = valid_q;

   // Refused-mask flag; a new refusal wins over a write-one clear.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         err_q <= 1'b0;
      else if (go_bad)
         err_q <= 1'b1;
      else if (wr_stat && reg_wdata[`IPA_STAT_ERR_BIT])
         err_q <= 1'b0;
   end

   // Count of completed invalidations, wrapping.
   // Software can poll it to see that a command it issued has been applied.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         done_q <= `IPA_ZERO32;
      else if (inv_busy)
         done_q <= done_q + 32'h0000_0001;
   end

   // Number of live entries, shown in the status word.
   always_comb
   begin
      valid_cnt = 8'h00;
      for (int i = 0; i < ENTRIES; i++)
         valid_cnt = valid_cnt + {7'h00, valid_q[i]};
   end

   // Lookup ignores address bits above the guest address width as well.
   always_comb
   begin
      lk_any      = 1'b0;
      lk_any_leaf = 1'b0;
      for (int i = 0; i < ENTRIES; i++)
      begin
         if (valid_q[i] && (did_mem[i] == lk_did) &&
             (((page_mem[i] ^ lk_page) & MAX_GUEST_ADDR_WIDTH_KEEP) == '0))
         begin
            lk_any      = 1'b1;
            lk_any_leaf = lk_any_leaf | leaf_q[i];
         end
      end
   end

   // Lookup answer is registered, one cycle after the request.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         lk_hit_q  <= 1'b0;
         lk_leaf_q <= 1'b0;
      end
      else
      begin
         lk_hit_q  <= lk_en && lk_any;
         lk_leaf_q <= lk_en && lk_any_leaf;
      end
   end

   // Lookup answers come straight from their flip-flops.
   assign lk_hit  = lk_hit_q;
   assign lk_leaf = lk_leaf_q;

   // Read mux. The address words answer zero: their content is not meant to be
   // read back, and a fixed value keeps software from relying on it.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_q <= `IPA_ZERO32;
      else if (reg_rd)
      begin
         case (reg_addr)
            `IPA_ECAP_OFF:
            begin
               rdata_q <= `IPA_ZERO32;
               rdata_q[`IPA_ECAP_IRO_LSB +: 8]  <= `IPA_IVA_LO_OFF >> `IPA_QWORD_SHIFT;
               rdata_q[`IPA_ECAP_MAM_LSB +: 6]  <= MAX_MASK_V;
               rdata_q[`IPA_ECAP_MAX_GUEST_ADDR_WIDTH_LSB +: 8] <= MAX_GUEST_ADDR_WIDTH_V;
            end
            `IPA_IVA_LO_OFF:
               rdata_q <= `IPA_ZERO32;
            `IPA_IVA_HI_OFF:
               rdata_q <= `IPA_ZERO32;
            `IPA_CMD_OFF:
            begin
               rdata_q <= `IPA_ZERO32;
               rdata_q[`IPA_CMD_DID_LSB +: DIDW] <= did_q;
            end
            `IPA_STAT_OFF:
            begin
               rdata_q <= `IPA_ZERO32;
               rdata_q[`IPA_STAT_BUSY_BIT]     <= inv_busy;
               rdata_q[`IPA_STAT_ERR_BIT]      <= err_q;
               rdata_q[`IPA_STAT_CNT_LSB +: 8] <= valid_cnt;
            end
            `IPA_DONE_OFF:
               rdata_q <= done_q;
            default:
               rdata_q <= `IPA_ZERO32;
         endcase
      end
      else
         rdata_q <= `IPA_ZERO32;
   end

   // Read data is registered, so it stands only in the cycle after the strobe.
   assign reg_rdata = rdata_q;
endmodule

/* shared/ipa_cfg.svh */
// Register offsets, field positions and reset values of the page invalidation block.
`ifndef IPA_CFG_SVH
`define IPA_CFG_SVH

// Byte offsets of the 32-bit register words.
`define IPA_ECAP_OFF      8'h00
`define IPA_IVA_LO_OFF    8'h10
`define IPA_IVA_HI_OFF    8'h14
`define IPA_CMD_OFF       8'h18
`define IPA_STAT_OFF      8'h1c
`define IPA_DONE_OFF      8'h20

// Shift that turns a byte offset into a quadword index.
`define IPA_QWORD_SHIFT   3

// Fields of the low address word.
`define IPA_MASK_LSB      0
`define IPA_MASK_MSB      5
`define IPA_HINT_BIT      6
`define IPA_ADDR_LSB      12
`define IPA_ADDR_MSB      31
`define IPA_PAGE_SHIFT    12

// Fields of the command word.
`define IPA_CMD_GO_BIT    0
`define IPA_CMD_DID_LSB   16

// Fields of the status word.
`define IPA_STAT_BUSY_BIT 0
`define IPA_STAT_ERR_BIT  1
`define IPA_STAT_CNT_LSB  8

// Fields of the extended capability word.
`define IPA_ECAP_IRO_LSB  0
`define IPA_ECAP_MAM_LSB  16
`define IPA_ECAP_MAX_GUEST_ADDR_WIDTH_LSB 24

// Reset values.
`define IPA_ZERO32        32'h0000_0000
`define IPA_PAGE_RST      52'h0_0000_0000_0000
`define IPA_PAGE_LO_RST   20'h0_0000
`define IPA_MASK_RST      6'h00

`endif

/* shared/ipa_pkg.sv */
// Types shared by the page invalidation block.
package ipa_pkg;
   typedef logic [51:0] ipa_page_type;
   typedef logic [5:0]  ipa_mask_type;
   typedef enum logic [0:0]
   {
      IPA_IDLE  = 1'b0,
      IPA_APPLY = 1'b1
   } ipa_state_type;
endpackage

/* shared/ipa_req_if.sv */
// Interface that carries one pending page invalidation request between modules.
`timescale 1ns/1ps
interface ipa_req_if #(parameter int DIDW = 16);
   import ipa_pkg::*;
   ipa_page_type    page;   // Page number, address bits 63:12.
   ipa_mask_type    mask;   // Order of the naturally aligned page group.
   logic            hint;   // Non-leaf entries may be kept when high.
   logic [DIDW-1:0] domain_identifier;    // Domain whose entries are targeted.
   modport src (output page, output mask, output hint);
   modport cmd (output domain_identifier);
   modport dst (input page, input mask, input hint, input domain_identifier);
endinterface

/* design/ipa_addr_reg.sv */
// Write-only page address register feeding the invalidation request.
`timescale 1ns/1ps
`include "ipa_cfg.svh"
module ipa_addr_reg
   import ipa_pkg::*;
(
   input  wire logic        clk,      // System clock.
   input  wire logic        sys_rst,  // Synchronous reset, active high.
   input  wire logic        wr_lo,    // Write pulse for the low word.
   input  wire logic        wr_hi,    // Write pulse for the high word.
   input  wire logic [31:0] wdata,    // Write data.
   ipa_req_if.src           req       // Request fields driven out.
);
   logic [19:0]  page_lo_q;
   logic [31:0]  page_hi_q;
   ipa_mask_type mask_q;
   logic         hint_q;

   // Low word holds page bits, hint and mask; bits 11:7 are simply never stored.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         page_lo_q <= `IPA_PAGE_LO_RST;
         hint_q    <= 1'b0;
         mask_q    <= `IPA_MASK_RST;
      end
      else if (wr_lo)
      begin
         page_lo_q <= wdata[`IPA_ADDR_MSB:`IPA_ADDR_LSB];
         hint_q    <= wdata[`IPA_HINT_BIT];
         mask_q    <= wdata[`IPA_MASK_MSB:`IPA_MASK_LSB];
      end
   end

   // High word holds address bits 63:32, kept apart so each half has one writer.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         page_hi_q <= `IPA_ZERO32;
      else if (wr_hi)
         page_hi_q <= wdata;
   end

   // Stored fields go straight onto the request interface.
   assign req.page = {page_hi_q, page_lo_q};
   assign req.mask = mask_q;
   assign req.hint = hint_q;
endmodule

/* design/ipa_match.sv */
// Comparator that decides whether one cached entry falls inside the request.
`timescale 1ns/1ps
module ipa_match
   import ipa_pkg::*;
#(
   parameter int MAX_GUEST_ADDR_WIDTH = 48,  // Supported guest address width.
   parameter int DIDW = 16   // Domain identifier width.
)
(
   ipa_req_if.dst                    req,        // Pending request fields.
   input  wire logic                 ent_valid,  // Entry holds a translation.
   input  wire logic    [DIDW-1:0]   ent_did,    // Entry domain.
   input  wire ipa_page_type         ent_page,   // Entry page number.
   output logic                      hit         // Entry matches the request.
);
   // Page bits that exist below the guest address width.
   localparam ipa_page_type MAX_GUEST_ADDR_WIDTH_KEEP = ipa_page_type'((53'h1 << (MAX_GUEST_ADDR_WIDTH - 12)) - 53'h1);

   ipa_page_type mask_keep;

   // Mask order n drops page bits n-1:0, covering 2^n aligned pages.
   assign mask_keep = ~ipa_page_type'((53'h1 << req.mask) - 53'h1);

   // Bits at or above the guest address width take no part in the match.
   assign hit = ent_valid && (ent_did == req.domain_identifier) &&
                (((ent_page ^ req.page) & mask_keep & MAX_GUEST_ADDR_WIDTH_KEEP) == '0);
endmodule

/* sim/ipa_top_checker.sv */
// Concurrent checks on the register port, invalidation pulse and lookup answer.
`timescale 1ns/1ps
module ipa_top_checker
#(
   parameter int ENTRIES  = 8,  // Cached entries.
   parameter int MAX_GUEST_ADDR_WIDTH     = 48, // Guest address width.
   parameter int MAX_MASK = 9   // Largest mask order.
)
(
   input wire logic               clk,         // Clock.
   input wire logic               sys_rst,     // Reset.
   input wire logic [7:0]         reg_addr,    // Address.
   input wire logic [31:0]        reg_wdata,   // Write data.
   input wire logic               reg_wr,      // Write strobe.
   input wire logic               reg_rd,      // Read strobe.
   input wire logic [31:0]        reg_rdata,   // Read data.
   input wire logic               lk_en,       // Lookup request.
   input wire logic               lk_hit,      // Lookup hit.
   input wire logic               lk_leaf,     // Hit is a leaf.
   input wire logic               inv_busy,    // Invalidation applied.
   input wire logic [ENTRIES-1:0] entry_valid  // Valid bits.
);
   logic [5:0] mask_q;
   logic       go_cmd;
   logic       rd_ecap;
   // Shadow of the stored mask, so an accepted command can be told from a refused one.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mask_q <= 6'h00;
      else if (reg_wr && reg_addr == 8'h10)
         mask_q <= reg_wdata[5:0];
   end
   // A command counts only while no invalidation is in flight.
   assign go_cmd  = reg_wr && reg_addr == 8'h18 && reg_wdata[0] && !inv_busy;
   assign rd_ecap = reg_rd && reg_addr == 8'h00;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   iva_read_zero_a: assert property (
      reg_rd && (reg_addr == 8'h10 || reg_addr == 8'h14) |=> reg_rdata == 32'h0)
      else $error("address register read returned data");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside the answer cycle");
   ecap_offset_a: assert property (
      rd_ecap |=> reg_rdata[7:0] == 8'h02 && reg_rdata[31:24] == 8'(MAX_GUEST_ADDR_WIDTH))
      else $error("capability offset or width wrong");
   ecap_mask_a: assert property (rd_ecap |=> reg_rdata[21:16] == 6'(MAX_MASK))
      else $error("capability mask limit wrong");
   go_busy_a: assert property (go_cmd && mask_q <= 6'(MAX_MASK) |=> inv_busy)
      else $error("accepted command did not start");
   go_refused_a: assert property (go_cmd && mask_q > 6'(MAX_MASK) |=> !inv_busy)
      else $error("oversize mask was applied");
   busy_single_a: assert property (inv_busy |=> !inv_busy)
      else $error("busy longer than one cycle");
   drop_after_busy_a: assert property (
      |($past(entry_valid) & ~entry_valid) |-> $past(inv_busy))
      else $error("entry dropped without invalidation");
   lookup_answer_a: assert property ((lk_hit || lk_leaf) |-> $past(lk_en) && lk_hit)
      else $error("lookup answer without request");
endmodule

bind ipa_top ipa_top_checker #(
   .ENTRIES  (ENTRIES),
   .MAX_GUEST_ADDR_WIDTH     (MAX_GUEST_ADDR_WIDTH),
   .MAX_MASK (MAX_MASK)
) i_ipa_top_checker (
   .clk         (clk),
   .sys_rst     (sys_rst),
   .reg_addr    (reg_addr),
   .reg_wdata   (reg_wdata),
   .reg_wr      (reg_wr),
   .reg_rd      (reg_rd),
   .reg_rdata   (reg_rdata),
   .lk_en       (lk_en),
   .lk_hit      (lk_hit),
   .lk_leaf     (lk_leaf),
   .inv_busy    (inv_busy),
   .entry_valid (entry_valid)
);

/* sim/ipa_top_tb.sv */
// Self-checking bench for the page invalidation unit, driven through its register port.
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module ipa_top_tb
   import ipa_pkg::*;
();
   logic         clk       = 1'b0;
   logic         sys_rst   = 1'b1;
   logic [7:0]   reg_addr  = 8'h00;
   logic [31:0]  reg_wdata = 32'h0;
   logic         reg_wr    = 1'b0;
   logic         reg_rd    = 1'b0;
   logic [31:0]  reg_rdata;
   logic         fill_en   = 1'b0;
   logic [2:0]   fill_idx  = 3'h0;
   logic         fill_leaf = 1'b0;
   logic [15:0]  fill_did  = 16'h0;
   ipa_page_type fill_page = 52'h0;
   logic         lk_en     = 1'b0;
   logic [15:0]  lk_did    = 16'h0;
   ipa_page_type lk_page   = 52'h0;
   logic         lk_hit;
   logic         lk_leaf;
   logic         inv_busy;
   logic [7:0]   entry_valid;
   int           mismatches = 0;
   int           n_checks   = 0;
   int           cycles     = 0;
   // Entry set: slot 2 is non-leaf, slot 5 another domain, slot 6 differs above the width.
   localparam ipa_page_type PAGE [8] = '{52'h100, 52'h101, 52'h100, 52'h103,
                                        52'h104, 52'h100, 52'h10_0000_0100, 52'h300};
   localparam logic [7:0]   LEAF     = 8'hfb;

   ipa_top i_ipa_top (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .reg_rdata   (reg_rdata),
      .fill_en     (fill_en),
      .fill_idx    (fill_idx),
      .fill_leaf   (fill_leaf),
      .fill_did    (fill_did),
      .fill_page   (fill_page),
      .lk_en       (lk_en),
      .lk_did      (lk_did),
      .lk_page     (lk_page),
      .lk_hit      (lk_hit),
      .lk_leaf     (lk_leaf),
      .inv_busy    (inv_busy),
      .entry_valid (entry_valid)
   );

   // Clock of 10 ns period.
   always #5 clk = ~clk;

   // Prints the verdict and ends the run.
   task automatic wrap_up();
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // A hang is cut short well beyond the roughly 120 cycles the tests need.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data is looked at only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, exp)
   endtask

   // Loads all slots back to back with fill held high.
   task automatic fill_all();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         fill_en   <= 1'b1;
         fill_idx  <= 3'(i);
         fill_leaf <= LEAF[i];
         fill_did  <= (i == 5) ? 16'h0006 : 16'h0005;
         fill_page <= PAGE[i];
      end
      @(posedge clk);
      fill_en <= 1'b0;
      #1;
      `CHK(entry_valid, 8'hff)
   endtask

   // Refills, programs the address register, issues the command for domain 5, checks.
   task automatic inval(input ipa_page_type p, input logic [5:0] m, input logic h,
                        input logic [4:0] rsv, input logic [7:0] exp);
      fill_all();
      wr(8'h10, {p[19:0], rsv, h, m});
      wr(8'h14, p[51:20]);
      wr(8'h18, 32'h0005_0001);
      #1;
      `CHK(inv_busy, m <= 6'h09)
      @(posedge clk);
      #1;
      `CHK(entry_valid, exp)
   endtask

   task automatic lookup(input logic hit, input logic leaf);
      @(posedge clk);
      lk_en   <= 1'b1;
      lk_did  <= 16'h0005;
      lk_page <= 52'h100;
      @(posedge clk);
      lk_en <= 1'b0;
      #1;
      `CHK(lk_hit, hit)
      `CHK(lk_leaf, leaf)
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h3009_0002);
      inval(52'h100, 6'h00, 1'b0, 5'h00, 8'hba);
      lookup(1'b0, 1'b0);
      inval(52'h100, 6'h00, 1'b1, 5'h00, 8'hbe);
      lookup(1'b1, 1'b0);
      inval(52'h101, 6'h02, 1'b0, 5'h00, 8'hb0);
      inval(52'h1ff, 6'h09, 1'b0, 5'h00, 8'ha0);
      inval(52'hf_fff0_0000_0100, 6'h00, 1'b0, 5'h1f, 8'hba);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0);
      rd(8'h20, 32'h5);
      inval(52'h100, 6'h0a, 1'b0, 5'h00, 8'hff);
      lookup(1'b1, 1'b1);
      rd(8'h1c, 32'h0000_0802);
      wr(8'h1c, 32'h0000_0002);
      rd(8'h1c, 32'h0000_0800);
      rd(8'h3c, 32'h0);
      wrap_up();
   end
endmodule
